// [async_word_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

module async_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // filling side
  input wire logic in_clk,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  input wire logic out_clk,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // reset
  input wire logic nrst
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin;
  logic [AW:0] rbin;
  logic [AW:0] wgray;
  logic [AW:0] rgray;
  logic [AW:0] rgray_s1, rgray_s2, rgray_s3, rgray_w;
  logic [AW:0] wgray_s1, wgray_s2, wgray_s3, wgray_r;

  // full compares against a settled copy of the far pointer, so it errs safe
  assign in_ready = (wgray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
  assign out_valid = (rgray != wgray_r);
  assign out_data = mem[rbin[AW-1:0]];

  always_ff @(posedge in_clk) begin
    if (in_valid && in_ready) begin
      mem[wbin[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge in_clk or negedge nrst) begin
    if (!nrst) begin
      wbin <= '0;
      wgray <= '0;
    end else if (in_valid && in_ready) begin
      wbin <= wbin + 1'b1;
      wgray <= to_gray(wbin + 1'b1);
    end
  end

  always_ff @(posedge out_clk or negedge nrst) begin
    if (!nrst) begin
      rbin <= '0;
      rgray <= '0;
    end else if (out_valid && out_ready) begin
      rbin <= rbin + 1'b1;
      rgray <= to_gray(rbin + 1'b1);
    end
  end

  // pointer is accepted only once stages two and three agree
  always_ff @(posedge in_clk or negedge nrst) begin
    if (!nrst) begin
      rgray_s1 <= '0;
      rgray_s2 <= '0;
      rgray_s3 <= '0;
      rgray_w <= '0;
    end else begin
      rgray_s1 <= rgray;
      rgray_s2 <= rgray_s1;
      rgray_s3 <= rgray_s2;
      if (rgray_s2 == rgray_s3) begin
        rgray_w <= rgray_s3;
      end
    end
  end

  always_ff @(posedge out_clk or negedge nrst) begin
    if (!nrst) begin
      wgray_s1 <= '0;
      wgray_s2 <= '0;
      wgray_s3 <= '0;
      wgray_r <= '0;
    end else begin
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
      wgray_s3 <= wgray_s2;
      if (wgray_s2 == wgray_s3) begin
        wgray_r <= wgray_s3;
      end
    end
  end
endmodule : async_word_fifo

`default_nettype wire

// [sram_ddr_data_port.sv]
// What this block does
// [R1] capture a word on both input clock edges
// [R2] write bus width 9, 18 or 36
// [R3] unused balls still seen by scan capture
// [R4] echo clock edges aligned with read data
// [R5] echo clocks run even while outputs float
// [R6] launch on output clocks, else input clocks
// [R7] output bus driven only by reads
// [R8] read bus width matches write width
// [R9] first word at primary, second at complementary
// [R10] read words at t+1 complement, t+2 primary
// [R11] tied output clocks stay high, never toggle
// [R12] outputs float when no word is scheduled
package sram_port_pkg;
  localparam int BALL_W = 36;
  localparam int WIDTH_X9 = 9;
  localparam int WIDTH_X18 = 18;
  localparam int WIDTH_X36 = 36;
  localparam int BUF_DEPTH = 8;
  localparam int TIE_CNT_W = 4;
  localparam logic [TIE_CNT_W-1:0] TIE_LIMIT = 4'h8;
  localparam logic [BALL_W-1:0] BUS_ZERO = 36'h0_0000_0000;
  localparam logic [BALL_W-1:0] BUS_ONES = 36'hF_FFFF_FFFF;

  typedef struct packed {
    logic [BALL_W-1:0] second;
    logic [BALL_W-1:0] first;
  } burst_pair_s;

  localparam int PAIR_W = $bits(burst_pair_s);

  function automatic logic [BALL_W-1:0] lane_mask(input int width);
    return BUS_ONES >> (BALL_W - width);
  endfunction : lane_mask
endpackage : sram_port_pkg

`timescale 1ns/10ps
`default_nettype none

module sram_ddr_data_port #(
  parameter int DATA_W = sram_port_pkg::WIDTH_X36
) (
  // core clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // link clocks from the controller
  input wire logic k_clk,
  input wire logic c_clk,
  input wire logic c_clk_n,
  // command decoder, k_clk domain
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire sram_port_pkg::burst_pair_s rd_pair,
  output logic write_ready,
  // data balls
  input wire logic [sram_port_pkg::BALL_W-1:0] wdata_in,
  output logic [sram_port_pkg::BALL_W-1:0] rdata_out,
  output logic [sram_port_pkg::BALL_W-1:0] rdata_oe,
  input wire logic [sram_port_pkg::BALL_W-1:0] rdata_pad_in,
  // echo clocks
  output logic echo_strobe,
  output logic echo_strobe_n,
  // boundary scan capture
  output logic [sram_port_pkg::BALL_W-1:0] scan_d_level,
  output logic [sram_port_pkg::BALL_W-1:0] scan_q_level,
  // written bursts toward the array, sys_clk domain
  output logic wr_valid,
  input wire logic wr_ready,
  output sram_port_pkg::burst_pair_s wr_pair
);
  import sram_port_pkg::*;

  // [R2] unused lanes masked
  localparam logic [BALL_W-1:0] USED = lane_mask(DATA_W);

  logic c_both_high;
  logic tie_s1, tie_s2, tie_s3;
  logic tie_level;
  logic [TIE_CNT_W-1:0] tie_cnt;
  logic c_tied;
  logic out_clk;
  logic wr_first_pend;
  logic [BALL_W-1:0] w_first;
  logic [BALL_W-1:0] w_second;
  logic w_second_ok;
  burst_pair_s push_pair;
  logic push_valid;
  logic rd_req;
  burst_pair_s rd_hold;
  logic rd_mid;
  burst_pair_s mid_pair;
  logic sched;
  burst_pair_s sched_pair;
  logic first_on;
  logic second_on;
  logic [BALL_W-1:0] q_first;
  logic [BALL_W-1:0] q_second;

  // tied-high detect: a toggling pair is never both high for long
  assign c_both_high = c_clk & c_clk_n;

  always_ff @(posedge k_clk or negedge nrst) begin
    if (!nrst) begin
      tie_s1 <= 1'b0;
      tie_s2 <= 1'b0;
      tie_s3 <= 1'b0;
    end else begin
      tie_s1 <= c_both_high;
      tie_s2 <= tie_s1;
      tie_s3 <= tie_s2;
    end
  end

  always_ff @(posedge k_clk or negedge nrst) begin
    if (!nrst) begin
      tie_level <= 1'b0;
    end else if (tie_s2 == tie_s3) begin
      tie_level <= tie_s3;
    end
  end

  // [R11] relies on a static tie
  always_ff @(posedge k_clk or negedge nrst) begin
    if (!nrst) begin
      tie_cnt <= '0;
      c_tied <= 1'b0;
    end else begin
      if (!tie_level) begin
        tie_cnt <= '0;
      end else if (tie_cnt != TIE_LIMIT) begin
        tie_cnt <= tie_cnt + 1'b1;
      end
      c_tied <= (tie_cnt == TIE_LIMIT);
    end
  end

  // [R6] output clock select
  // the switch is only clean because a tied pair never moves again
  assign out_clk = c_tied ? k_clk : c_clk;

  // [R4] echo follows launch clock
  // [R5] free running echo
  assign echo_strobe = out_clk;
  assign echo_strobe_n = ~out_clk;

  // [R1] primary edge capture
  // [R9] first word at primary
  always_ff @(posedge k_clk or negedge nrst) begin
    if (!nrst) begin
      wr_first_pend <= 1'b0;
      w_first <= BUS_ZERO;
    end else begin
      wr_first_pend <= wr_cmd;
      if (wr_cmd) begin
        w_first <= wdata_in & USED;
      end
    end
  end

  // [R1] complementary edge capture
  // [R9] second word follows
  // k_clk is taken as the true inverse of the complementary input clock
  always_ff @(negedge k_clk or negedge nrst) begin
    if (!nrst) begin
      w_second <= BUS_ZERO;
      w_second_ok <= 1'b0;
    end else begin
      w_second_ok <= wr_first_pend;
      if (wr_first_pend) begin
        w_second <= wdata_in & USED;
      end
    end
  end

  // pair pushed on the primary edge after the complementary capture
  assign push_valid = w_second_ok;
  assign push_pair = '{second: w_second, first: w_first};

  // the controller cannot be stalled: write_ready low means bursts are dropped
  async_word_fifo #(
    .WIDTH(PAIR_W),
    .DEPTH(BUF_DEPTH)
  ) u_write_buf (
    .in_clk(k_clk),
    .in_data(push_pair),
    .in_valid(push_valid),
    .in_ready(write_ready),
    .out_clk(sys_clk),
    .out_data(wr_pair),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .nrst(nrst)
  );

  // [R3] every ball sampled for scan
  always_ff @(posedge k_clk or negedge nrst) begin
    if (!nrst) begin
      scan_d_level <= BUS_ZERO;
      scan_q_level <= BUS_ZERO;
    end else begin
      scan_d_level <= wdata_in;
      scan_q_level <= rdata_pad_in;
    end
  end

  // [R7] read command registered
  always_ff @(posedge k_clk or negedge nrst) begin
    if (!nrst) begin
      rd_req <= 1'b0;
      rd_hold <= '0;
    end else begin
      rd_req <= rd_cmd;
      if (rd_cmd) begin
        rd_hold <= rd_pair;
      end
    end
  end

  // [R10] half-cycle hand-off stage
  // a lagging output clock must not see the read in its own cycle
  always_ff @(negedge k_clk or negedge nrst) begin
    if (!nrst) begin
      rd_mid <= 1'b0;
      mid_pair <= '0;
    end else begin
      rd_mid <= rd_req;
      mid_pair <= rd_hold;
    end
  end

  // [R10] second word at t+2
  // output clock must run at k_clk rate, lagging under half a period
  always_ff @(posedge out_clk or negedge nrst) begin
    if (!nrst) begin
      sched <= 1'b0;
      sched_pair <= '0;
      second_on <= 1'b0;
      q_second <= BUS_ZERO;
    end else begin
      sched <= rd_mid;
      sched_pair <= mid_pair;
      second_on <= sched;
      q_second <= sched_pair.second & USED;
    end
  end

  // [R10] first word at t+1
  always_ff @(negedge out_clk or negedge nrst) begin
    if (!nrst) begin
      first_on <= 1'b0;
      q_first <= BUS_ZERO;
    end else begin
      first_on <= sched;
      q_first <= sched_pair.first & USED;
    end
  end

  // [R8] only used lanes enabled
  // [R12] float when nothing scheduled
  assign rdata_out = out_clk ? q_second : q_first;
  assign rdata_oe = (out_clk ? second_on : first_on) ? USED : BUS_ZERO;

  // [R1] first word check
  property p_first_capture;
    @(posedge k_clk) disable iff (!nrst)
      wr_cmd |=> (w_first == ($past(wdata_in) & USED));
  endproperty
  a_first_capture: assert property (p_first_capture) // [R1]
    else $error("first write word not captured");

  // [R9] pair order check
  property p_pair_order;
    @(posedge k_clk) disable iff (!nrst)
      wr_cmd |=> (push_valid && push_pair.first == ($past(wdata_in) & USED));
  endproperty
  a_pair_order: assert property (p_pair_order) // [R9]
    else $error("write pair not pushed in order");

  // [R2] width check
  property p_write_width;
    @(posedge k_clk) disable iff (!nrst)
      ((w_first | w_second) & ~USED) == BUS_ZERO;
  endproperty
  a_write_width: assert property (p_write_width) // [R2]
    else $error("write lane beyond width");

  // [R3] scan check
  property p_scan_ball;
    @(posedge k_clk) disable iff (!nrst)
      1'b1 |=> (scan_d_level == $past(wdata_in) && scan_q_level == $past(rdata_pad_in));
  endproperty
  a_scan_ball: assert property (p_scan_ball) // [R3]
    else $error("scan capture lost a ball");

  // [R4] echo alignment check
  property p_echo_align;
    @(posedge k_clk) disable iff (!nrst)
      c_tied |-> (!echo_strobe && rdata_out == q_first);
  endproperty
  a_echo_align: assert property (p_echo_align) // [R4]
    else $error("echo not aligned with data");

  // [R5] echo running check
  property p_echo_run;
    @(negedge k_clk) disable iff (!nrst)
      (c_tied && !first_on && !second_on) |-> (echo_strobe && !echo_strobe_n);
  endproperty
  a_echo_run: assert property (p_echo_run) // [R5]
    else $error("echo stopped while bus floats");

  // [R6] first word launch check
  property p_first_launch;
    @(posedge k_clk) disable iff (!nrst)
      (c_tied && rd_cmd) ##2 c_tied |->
        (first_on && q_first == ($past(rd_pair.first, 2) & USED));
  endproperty
  a_first_launch: assert property (p_first_launch) // [R6]
    else $error("first read word not launched");

  // [R10] second word launch check
  property p_second_launch;
    @(posedge k_clk) disable iff (!nrst)
      (c_tied && rd_cmd) ##3 c_tied |->
        (second_on && q_second == ($past(rd_pair.second, 3) & USED));
  endproperty
  a_second_launch: assert property (p_second_launch) // [R10]
    else $error("second read word not launched");

  // [R7] no drive without read
  property p_read_only;
    @(posedge k_clk) disable iff (!nrst)
      (c_tied && $past(c_tied, 3) && !$past(rd_cmd, 3)) |-> !second_on;
  endproperty
  a_read_only: assert property (p_read_only) // [R7]
    else $error("bus driven without a read");

  // [R8] lane check
  property p_read_width;
    @(posedge k_clk) disable iff (!nrst)
      (rdata_oe & ~USED) == BUS_ZERO;
  endproperty
  a_read_width: assert property (p_read_width) // [R8]
    else $error("read lane beyond width");

  // [R12] float check
  property p_float_idle;
    @(posedge k_clk) disable iff (!nrst)
      (!first_on && !second_on) |-> (rdata_oe == BUS_ZERO);
  endproperty
  a_float_idle: assert property (p_float_idle) // [R12]
    else $error("bus driven while idle");

  c_write_burst: cover property (@(posedge k_clk) disable iff (!nrst) wr_cmd ##1 push_valid);
  c_read_burst: cover property (@(posedge k_clk) disable iff (!nrst) rd_cmd ##3 second_on);
  c_read_back: cover property (@(posedge k_clk) disable iff (!nrst) rd_cmd ##1 rd_cmd);
  c_tie_found: cover property (@(posedge k_clk) disable iff (!nrst) $rose(c_tied));
endmodule : sram_ddr_data_port

`default_nettype wire

// [ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none

module ctl_model (
  // mode
  input wire logic tie_c,
  // clocks
  output var logic k_clk,
  output logic c_clk,
  output logic c_clk_n,
  // commands and data
  output var logic wr_cmd,
  output var logic rd_cmd,
  output var sram_port_pkg::burst_pair_s rd_pair,
  output var logic [sram_port_pkg::BALL_W-1:0] wdata_in
);
  import sram_port_pkg::*;
  logic k_dly;
  initial begin
    k_clk = 1'b0;
    wr_cmd = 1'b0;
    rd_cmd = 1'b0;
    rd_pair = '0;
    wdata_in = BUS_ZERO;
    #1.3;
    forever #6 k_clk = ~k_clk;
  end
  // board skew on the out clocks
  assign #2 k_dly = k_clk;
  assign c_clk = tie_c | k_dly;
  assign c_clk_n = tie_c | ~k_dly;
  // word0 at rise, word1 at fall
  task automatic wr(input logic [BALL_W-1:0] a, input logic [BALL_W-1:0] b);
    wr_cmd = 1'b1;
    wdata_in = a;
    @(posedge k_clk) #1;
    wr_cmd = 1'b0;
    wdata_in = b;
    @(negedge k_clk) #1;
  endtask : wr
  // released bus shows the inverse, not the last word
  task automatic rel();
    @(posedge k_clk) #1;
    wdata_in = ~wdata_in;
  endtask : rel
  task automatic rd(input logic [BALL_W-1:0] f, input logic [BALL_W-1:0] s);
    rd_cmd = 1'b1;
    rd_pair = {s, f};
    @(posedge k_clk) #1;
    rd_cmd = 1'b0;
    rd_pair = ~rd_pair;
    @(negedge k_clk) #1;
  endtask : rd
  task automatic drive_d(input logic [BALL_W-1:0] v);
    wdata_in = v;
  endtask : drive_d
endmodule : ctl_model

`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  import sram_port_pkg::*;
  localparam logic [BALL_W-1:0] M = 36'h0_0003_FFFF;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic tie_c = 1'b0;
  logic wr_ready = 1'b0;
  logic [BALL_W-1:0] pad_ext = 36'hC_3C3C_3C3C;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic k_clk, c_clk, c_clk_n, wr_cmd, rd_cmd, write_ready;
  logic echo_strobe, echo_strobe_n, wr_valid;
  burst_pair_s rd_pair, wr_pair;
  logic [BALL_W-1:0] wdata_in, rdata_out, rdata_oe, pad, scan_d_level, scan_q_level;
  always #2.5 sys_clk = ~sys_clk;
  // driven lanes carry data, others the outside level
  // board delay keeps the pad off the capturing edge
  assign #1 pad = (rdata_oe & rdata_out) | (~rdata_oe & pad_ext);
  ctl_model i_ctl_model (.tie_c(tie_c), .k_clk(k_clk), .c_clk(c_clk), .c_clk_n(c_clk_n),
    .wr_cmd(wr_cmd), .rd_cmd(rd_cmd), .rd_pair(rd_pair), .wdata_in(wdata_in));
  sram_ddr_data_port #(.DATA_W(WIDTH_X18)) i_sram_ddr_data_port (.sys_clk(sys_clk),
    .nrst(nrst), .k_clk(k_clk), .c_clk(c_clk), .c_clk_n(c_clk_n), .wr_cmd(wr_cmd),
    .rd_cmd(rd_cmd), .rd_pair(rd_pair), .write_ready(write_ready), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rdata_oe(rdata_oe), .rdata_pad_in(pad),
    .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n), .scan_d_level(scan_d_level),
    .scan_q_level(scan_q_level), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_pair(wr_pair));
  task automatic chk_w(input logic [BALL_W-1:0] got, input logic [BALL_W-1:0] exp, string s);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp, input string s);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %b", $time, s, got);
    end
  endtask : chk_b
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic do_reset(input logic tie);
    nrst = 1'b0;
    tie_c = tie;
    repeat (4) @(posedge k_clk);
    @(posedge sys_clk) #1;
    nrst = 1'b1;
    // tie detector needs time to settle
    repeat (20) @(posedge k_clk);
  endtask : do_reset
  task automatic take(input logic [BALL_W-1:0] f, input logic [BALL_W-1:0] s);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk) #1;
      i++;
    end while (wr_valid !== 1'b1 && i < 100);
    chk_b(wr_valid, 1'b1, "wr_valid");
    chk_w(wr_pair.first, f, "word0");
    chk_w(wr_pair.second, s, "word1");
    wr_ready = 1'b1;
    @(posedge sys_clk) #1;
    wr_ready = 1'b0;
  endtask : take
  task automatic t_write();
    @(negedge k_clk) #1;
    i_ctl_model.wr(36'h1_2345_6789, 36'hE_DCBA_9876);
    i_ctl_model.wr(36'hF_0F0F_0F0F, 36'h0_F0F0_F0F0);
    i_ctl_model.rel();
    chk_w(rdata_oe, BUS_ZERO, "oe on write");
    take(36'h1_2345_6789 & M, 36'hE_DCBA_9876 & M);
    take(36'hF_0F0F_0F0F & M, 36'h0_F0F0_F0F0 & M);
    $display("test write done");
  endtask : t_write
  task automatic t_full();
    int i;
    @(negedge k_clk) #1;
    for (i = 0; i < 10; i++) begin
      i_ctl_model.wr({4{9'(i)}}, ~{4{9'(i)}});
    end
    i_ctl_model.rel();
    repeat (2) @(posedge k_clk);
    #1;
    chk_b(write_ready, 1'b0, "full");
    for (i = 0; i < BUF_DEPTH; i++) begin
      take({4{9'(i)}} & M, ~{4{9'(i)}} & M);
    end
    repeat (30) @(posedge sys_clk);
    #1;
    chk_b(wr_valid, 1'b0, "drained");
    chk_b(write_ready, 1'b1, "room");
    $display("test full done");
  endtask : t_full
  task automatic half(input logic [BALL_W-1:0] e, input logic on, input logic lvl);
    #4;
    if (on) chk_w(rdata_out & M, e & M, "rdata");
    chk_w(rdata_oe, on ? M : BUS_ZERO, "oe");
    chk_b(echo_strobe, lvl, "echo");
  endtask : half
  task automatic t_read();
    @(negedge k_clk) #1;
    fork
      begin
        i_ctl_model.rd(36'hA_5A5A_5A5A, 36'h5_A5A5_A5A5);
        i_ctl_model.rd(36'h1_1111_1111, 36'h2_2222_2222);
      end
      begin
        repeat (2) @(posedge k_clk);
        @(negedge k_clk) half(36'hA_5A5A_5A5A, 1'b1, 1'b0);
        @(posedge k_clk) half(36'h5_A5A5_A5A5, 1'b1, 1'b1);
        @(negedge k_clk) half(36'h1_1111_1111, 1'b1, 1'b0);
        @(posedge k_clk) half(36'h2_2222_2222, 1'b1, 1'b1);
        @(negedge k_clk) half(BUS_ZERO, 1'b0, 1'b0);
      end
    join
    $display("test read done");
  endtask : t_read
  task automatic t_echo();
    int i;
    for (i = 0; i < 3; i++) begin
      @(posedge k_clk) #4;
      chk_b(echo_strobe, 1'b1, "echo hi");
      chk_b(echo_strobe_n, 1'b0, "echo_n lo");
      chk_w(rdata_oe, BUS_ZERO, "float");
      @(negedge k_clk) #4;
      chk_b(echo_strobe, 1'b0, "echo lo");
      chk_b(echo_strobe_n, 1'b1, "echo_n hi");
    end
    $display("test echo done");
  endtask : t_echo
  task automatic t_scan();
    @(negedge k_clk) #1;
    i_ctl_model.drive_d(36'h9_8765_4321);
    pad_ext = 36'h6_789A_BCDE;
    repeat (2) @(posedge k_clk);
    #1;
    chk_w(scan_d_level, 36'h9_8765_4321, "scan d");
    chk_w(scan_q_level, 36'h6_789A_BCDE, "scan q");
    $display("test scan done");
  endtask : t_scan
  initial begin
    do_reset(1'b0);
    t_write();
    t_full();
    t_read();
    t_echo();
    t_scan();
    // second run with the out clocks tied
    do_reset(1'b1);
    t_read();
    t_echo();
    print_verdict();
  end
endmodule : tb

`default_nettype wire
